//--- rwk_pkg.sv
// package: register map, field positions and event carrier for the wake control block
package rwk_pkg;
  // ----------------------------------------------------------------
  // register map
  // ----------------------------------------------------------------
  localparam int unsigned RWK_ADDR_W = 12;
  localparam logic [11:0] RWK_PATTERN_PORT_OFS = 12'h128;
  localparam logic [11:0] RWK_CONTROL_STATUS_OFS = 12'h12C;
  localparam logic [11:0] RWK_OPTIONS_OFS = 12'h1F0;
  // ----------------------------------------------------------------
  // control/status field positions
  // ----------------------------------------------------------------
  localparam int unsigned RWK_REWIND_BIT = 31;
  localparam int unsigned RWK_UNICAST_EN_BIT = 9;
  localparam int unsigned RWK_FLAG_LO = 4;
  localparam int unsigned RWK_FLAG_HI = 7;
  localparam int unsigned RWK_EN_LO = 0;
  localparam int unsigned RWK_EN_HI = 3;
  localparam int unsigned RWK_RES_CLR_BIT = 0;
  // ----------------------------------------------------------------
  // sizes and reset values
  // ----------------------------------------------------------------
  localparam int unsigned RWK_STORE_WORDS = 40;
  localparam int unsigned RWK_FILTERS = 8;
  localparam logic [31:0] RWK_STORE_RST = 32'h0000_0000;
  localparam logic [3:0] RWK_FLAGS_RST = 4'h0;
  localparam logic [3:0] RWK_EN_RST = 4'h0;
  localparam logic [31:0] RWK_UNMAPPED_RD = 32'h0000_0000;
  // ----------------------------------------------------------------
  // received-frame events from the receive filters, one-cycle pulses
  // ----------------------------------------------------------------
  typedef struct packed {
    logic frame_valid;    // a valid frame finished
    logic da_lsb;         // destination address bit 0 of that frame
    logic station_match;  // destination equals station address
    logic pattern_match;  // frame matched the pattern store
    logic magic;          // magic wake packet seen
    logic broadcast;      // broadcast frame seen
  } rwk_rx_evt_t;
endpackage

//--- rwk_wake_ctrl.sv
// wake control: pattern store port, wake control/status register, wake request
//
// What this block does
// - first write after reset lands in entry 0
// - write pointer wraps to entry 0 after 40
// - reads return entries in order, pointer advancing
// - writing bit 31 rewinds both pointers, self-clearing
// - bit 9 wakes on global unicast frame
// - unicast wake also needs pattern wake enable
// - station address match sets status bit 7
// - pattern store match sets status bit 6
// - magic wake packet sets status bit 5
// - broadcast frame sets status bit 4
// - status bits clear on write-one or resume option
// - bit 3 enables wake on station match
// - bit 2 enables wake on pattern match
// - bit 1 enables wake on magic wake frame
// - bit 0 enables wake on broadcast
//
// Strobed register access was chosen for this implementation.
`timescale 1ns/1ps
`default_nettype none
module rwk_wake_ctrl
#(
  parameter int unsigned STORE_WORDS = rwk_pkg::RWK_STORE_WORDS
)
(
  input wire logic clk_in,
  input wire logic arst_n_in,
  input wire logic [rwk_pkg::RWK_ADDR_W-1:0] reg_addr_in,
  input wire logic [31:0] reg_wdata_in,
  input wire logic reg_wr_in,
  input wire logic reg_rd_in,
  output logic [31:0] reg_rdata_out,
  input wire rwk_pkg::rwk_rx_evt_t rx_evt_in,
  input wire logic resume_done_in,
  input wire logic [5:0] match_idx_in,
  output logic [31:0] match_data_out,
  output logic wake_req_out
);
  import rwk_pkg::*;

  // ----------------------------------------------------------------
  // elaboration checks
  // ----------------------------------------------------------------
  generate
    if (STORE_WORDS < 1 || STORE_WORDS > 64)
    begin : g_bad_depth
      $error("STORE_WORDS must be 1 to 64");
    end
  endgenerate

  localparam logic [5:0] LAST_IDX = 6'(STORE_WORDS - 1);

  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  logic [31:0] store_ff [STORE_WORDS];
  logic [5:0] wr_ptr_ff;
  logic [5:0] rd_ptr_ff;
  logic [31:0] rdata_ff;
  logic [31:0] match_data_ff;
  logic [3:0] flags_ff;       // station, pattern, magic, broadcast
  logic [3:0] enables_ff;     // same order as flags_ff
  logic global_unicast_wake_enable_ff;
  logic unicast_wake_ff;
  logic resume_clears_wake_flags_ff;
  logic wake_req_ff;

  logic port_wr;
  logic port_rd;
  logic csr_wr;
  logic opt_wr;
  logic rewind;
  logic uni_evt;
  logic [3:0] evt_vec;
  logic [3:0] nxt_flags;
  logic nxt_unicast;
  logic [5:0] nxt_wr_ptr;
  logic [5:0] nxt_rd_ptr;

  // ----------------------------------------------------------------
  // address decode
  // ----------------------------------------------------------------
  assign port_wr = reg_wr_in && (reg_addr_in == RWK_PATTERN_PORT_OFS);
  assign port_rd = reg_rd_in && (reg_addr_in == RWK_PATTERN_PORT_OFS);
  assign csr_wr = reg_wr_in && (reg_addr_in == RWK_CONTROL_STATUS_OFS);
  assign opt_wr = reg_wr_in && (reg_addr_in == RWK_OPTIONS_OFS);
  assign rewind = csr_wr && reg_wdata_in[RWK_REWIND_BIT];

  // ----------------------------------------------------------------
  // pointer stepping with wrap
  // ----------------------------------------------------------------
  assign nxt_wr_ptr = (wr_ptr_ff == LAST_IDX) ? 6'h00 : wr_ptr_ff + 6'h01;
  assign nxt_rd_ptr = (rd_ptr_ff == LAST_IDX) ? 6'h00 : rd_ptr_ff + 6'h01;

  // write pointer: advance per port write, rewind on request
  always_ff @(posedge clk_in or negedge arst_n_in)
  begin
    if (!arst_n_in)
      wr_ptr_ff <= 6'h00;
    else if (rewind)
      wr_ptr_ff <= 6'h00;
    else if (port_wr)
      wr_ptr_ff <= nxt_wr_ptr;
  end

  // read pointer: advance per port read, rewind on request
  always_ff @(posedge clk_in or negedge arst_n_in)
  begin
    if (!arst_n_in)
      rd_ptr_ff <= 6'h00;
    else if (rewind)
      rd_ptr_ff <= 6'h00;
    else if (port_rd)
      rd_ptr_ff <= nxt_rd_ptr;
  end

  // ----------------------------------------------------------------
  // pattern store
  // ----------------------------------------------------------------
  generate
    for (genvar i = 0; i < STORE_WORDS; i++)
    begin : g_store
      // one entry, loaded when the write pointer names it
      always_ff @(posedge clk_in or negedge arst_n_in)
      begin
        if (!arst_n_in)
          store_ff[i] <= RWK_STORE_RST;
        else if (port_wr && (wr_ptr_ff == 6'(i)))
          store_ff[i] <= reg_wdata_in;
      end
    end
  endgenerate

  // matcher-side read of the store, one cycle latency
  always_ff @(posedge clk_in or negedge arst_n_in)
  begin
    if (!arst_n_in)
      match_data_ff <= RWK_STORE_RST;
    else if (32'(match_idx_in) < STORE_WORDS)
      match_data_ff <= store_ff[match_idx_in];
    else
      match_data_ff <= RWK_STORE_RST;
  end

  // ----------------------------------------------------------------
  // control and option bits
  // ----------------------------------------------------------------
  always_ff @(posedge clk_in or negedge arst_n_in)
  begin
    if (!arst_n_in)
    begin
      enables_ff <= RWK_EN_RST;
      global_unicast_wake_enable_ff <= 1'b0;
    end
    else if (csr_wr)
    begin
      enables_ff <= reg_wdata_in[RWK_EN_HI:RWK_EN_LO];
      global_unicast_wake_enable_ff <= reg_wdata_in[RWK_UNICAST_EN_BIT];
    end
  end

  // resume-clears option
  always_ff @(posedge clk_in or negedge arst_n_in)
  begin
    if (!arst_n_in)
      resume_clears_wake_flags_ff <= 1'b0;
    else if (opt_wr)
      resume_clears_wake_flags_ff <= reg_wdata_in[RWK_RES_CLR_BIT];
  end

  // ----------------------------------------------------------------
  // received-event flags: set wins over clear
  // ----------------------------------------------------------------
  assign evt_vec = {rx_evt_in.station_match, rx_evt_in.pattern_match,
                    rx_evt_in.magic, rx_evt_in.broadcast} & {4{rx_evt_in.frame_valid}};
  assign uni_evt = rx_evt_in.frame_valid && !rx_evt_in.da_lsb
                   && global_unicast_wake_enable_ff && enables_ff[2];

  always_comb
  begin
    nxt_flags = flags_ff;
    if (resume_done_in && resume_clears_wake_flags_ff)
      nxt_flags = RWK_FLAGS_RST;
    if (csr_wr)
      nxt_flags = nxt_flags & ~reg_wdata_in[RWK_FLAG_HI:RWK_FLAG_LO];
    nxt_flags = nxt_flags | evt_vec;
  end

  // unicast wake has no status bit; it clears on write-one to bit 6 or on any resume, option or not
  always_comb
  begin
    nxt_unicast = unicast_wake_ff;
    if (resume_done_in || (csr_wr && reg_wdata_in[RWK_FLAG_HI-1]))
      nxt_unicast = 1'b0;
    nxt_unicast = nxt_unicast | uni_evt;
  end

  // flag registers
  always_ff @(posedge clk_in or negedge arst_n_in)
  begin
    if (!arst_n_in)
    begin
      flags_ff <= RWK_FLAGS_RST;
      unicast_wake_ff <= 1'b0;
    end
    else
    begin
      flags_ff <= nxt_flags;
      unicast_wake_ff <= nxt_unicast;
    end
  end

  // ----------------------------------------------------------------
  // wake request
  // ----------------------------------------------------------------
  always_ff @(posedge clk_in or negedge arst_n_in)
  begin
    if (!arst_n_in)
      wake_req_ff <= 1'b0;
    else
      wake_req_ff <= (|(flags_ff & enables_ff)) || unicast_wake_ff;
  end

  // ----------------------------------------------------------------
  // read data, valid the cycle after the read strobe
  // ----------------------------------------------------------------
  always_ff @(posedge clk_in or negedge arst_n_in)
  begin
    if (!arst_n_in)
      rdata_ff <= RWK_UNMAPPED_RD;
    else if (port_rd)
      rdata_ff <= store_ff[rd_ptr_ff];
    else if (reg_rd_in && reg_addr_in == RWK_CONTROL_STATUS_OFS)
      rdata_ff <= {22'h0, global_unicast_wake_enable_ff, 1'b0, flags_ff, enables_ff};
    else if (reg_rd_in && reg_addr_in == RWK_OPTIONS_OFS)
      rdata_ff <= {31'h0, resume_clears_wake_flags_ff};
    else
      rdata_ff <= RWK_UNMAPPED_RD;
  end

  assign reg_rdata_out = rdata_ff;
  assign match_data_out = match_data_ff;
  assign wake_req_out = wake_req_ff;

  // ----------------------------------------------------------------
  // assertions
  // ----------------------------------------------------------------
  property p_store_write;
    @(posedge clk_in) disable iff (!arst_n_in)
    port_wr |=> store_ff[$past(wr_ptr_ff)] == $past(reg_wdata_in);
  endproperty
  a_store_write: assert property (p_store_write) else $error("store write lost");

  property p_wr_wrap;
    @(posedge clk_in) disable iff (!arst_n_in)
    (port_wr && wr_ptr_ff == LAST_IDX) |=> wr_ptr_ff == 6'h00;
  endproperty
  a_wr_wrap: assert property (p_wr_wrap) else $error("write pointer did not wrap");

  property p_port_read;
    @(posedge clk_in) disable iff (!arst_n_in)
    port_rd |=> (reg_rdata_out == store_ff[$past(rd_ptr_ff)])
      && (rd_ptr_ff == $past(nxt_rd_ptr));
  endproperty
  a_port_read: assert property (p_port_read) else $error("port read wrong");

  property p_rewind;
    @(posedge clk_in) disable iff (!arst_n_in)
    rewind |=> (wr_ptr_ff == 6'h00) && (rd_ptr_ff == 6'h00);
  endproperty
  a_rewind: assert property (p_rewind) else $error("pointers not rewound");

  property p_unicast_wake;
    @(posedge clk_in) disable iff (!arst_n_in)
    uni_evt |-> ##2 wake_req_out;
  endproperty
  a_unicast_wake: assert property (p_unicast_wake) else $error("unicast wake missed");

  property p_unicast_needs_pattern_en;
    @(posedge clk_in) disable iff (!arst_n_in)
    (!unicast_wake_ff && !enables_ff[2]) |=> !unicast_wake_ff;
  endproperty
  a_unicast_needs_pattern_en: assert property (p_unicast_needs_pattern_en)
    else $error("unicast wake without pattern enable");

  property p_station_flag;
    @(posedge clk_in) disable iff (!arst_n_in)
    (rx_evt_in.frame_valid && rx_evt_in.station_match) |=> flags_ff[3];
  endproperty
  a_station_flag: assert property (p_station_flag) else $error("station flag not set");

  property p_pattern_flag;
    @(posedge clk_in) disable iff (!arst_n_in)
    (rx_evt_in.frame_valid && rx_evt_in.pattern_match) |=> flags_ff[2];
  endproperty
  a_pattern_flag: assert property (p_pattern_flag) else $error("pattern flag not set");

  property p_magic_flag;
    @(posedge clk_in) disable iff (!arst_n_in)
    (rx_evt_in.frame_valid && rx_evt_in.magic) |=> flags_ff[1];
  endproperty
  a_magic_flag: assert property (p_magic_flag) else $error("magic flag not set");

  property p_bcast_flag;
    @(posedge clk_in) disable iff (!arst_n_in)
    (rx_evt_in.frame_valid && rx_evt_in.broadcast) |=> flags_ff[0];
  endproperty
  a_bcast_flag: assert property (p_bcast_flag) else $error("broadcast flag not set");

  property p_resume_clear;
    @(posedge clk_in) disable iff (!arst_n_in)
    (resume_done_in && resume_clears_wake_flags_ff && !rx_evt_in.frame_valid)
      |=> flags_ff == RWK_FLAGS_RST;
  endproperty
  a_resume_clear: assert property (p_resume_clear) else $error("resume did not clear");

  property p_station_wake;
    @(posedge clk_in) disable iff (!arst_n_in)
    (flags_ff[3] && enables_ff[3]) |=> wake_req_out;
  endproperty
  a_station_wake: assert property (p_station_wake) else $error("station wake missed");

  property p_pattern_wake;
    @(posedge clk_in) disable iff (!arst_n_in)
    (flags_ff[2] && enables_ff[2]) |=> wake_req_out;
  endproperty
  a_pattern_wake: assert property (p_pattern_wake) else $error("pattern wake missed");

  property p_magic_wake;
    @(posedge clk_in) disable iff (!arst_n_in)
    (flags_ff[1] && enables_ff[1]) |=> wake_req_out;
  endproperty
  a_magic_wake: assert property (p_magic_wake) else $error("magic wake missed");

  property p_bcast_wake;
    @(posedge clk_in) disable iff (!arst_n_in)
    (flags_ff[0] && enables_ff[0]) |=> wake_req_out;
  endproperty
  a_bcast_wake: assert property (p_bcast_wake) else $error("broadcast wake missed");

  property p_no_cause_no_wake;
    @(posedge clk_in) disable iff (!arst_n_in)
    (!(|(flags_ff & enables_ff)) && !unicast_wake_ff) |=> !wake_req_out;
  endproperty
  a_no_cause_no_wake: assert property (p_no_cause_no_wake) else $error("spurious wake");
endmodule
`default_nettype wire

//--- tb_rwk_wake_ctrl.sv
// testbench: register port, pattern store pointers, wake flags and wake request
`timescale 1ns/1ps
`default_nettype none
module tb_rwk_wake_ctrl;
  import rwk_pkg::*;
  // ----------------------------------------------------------------
  // signals
  // ----------------------------------------------------------------
  logic clk_in = 1'b0;
  logic arst_n_in = 1'b0;
  logic [11:0] reg_addr_in = 12'h000;
  logic [31:0] reg_wdata_in = 32'h0000_0000;
  logic reg_wr_in = 1'b0;
  logic reg_rd_in = 1'b0;
  logic [31:0] reg_rdata_out;
  rwk_rx_evt_t rx_evt_in = '0;
  logic resume_done_in = 1'b0;
  logic [5:0] match_idx_in = 6'h00;
  logic [31:0] match_data_out;
  logic wake_req_out;
  int error_cnt = 0;
  int num_checks = 0;
  logic [31:0] d;

  // clock, 20 ns period
  always #10 clk_in = ~clk_in;

  // device under test
  rwk_wake_ctrl #(.STORE_WORDS(40)) i_rwk_wake_ctrl (
    .clk_in(clk_in), .arst_n_in(arst_n_in), .reg_addr_in(reg_addr_in),
    .reg_wdata_in(reg_wdata_in), .reg_wr_in(reg_wr_in), .reg_rd_in(reg_rd_in),
    .reg_rdata_out(reg_rdata_out), .rx_evt_in(rx_evt_in), .resume_done_in(resume_done_in),
    .match_idx_in(match_idx_in), .match_data_out(match_data_out), .wake_req_out(wake_req_out)
  );

  // ----------------------------------------------------------------
  // bus and compare tasks
  // ----------------------------------------------------------------
  task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
    num_checks++;
    if (got !== exp)
    begin
      error_cnt++;
      $display("Error %s expected %h seen %h", name, exp, got);
    end
  endtask

  task automatic wr(input logic [11:0] a, input logic [31:0] v);
    @(posedge clk_in);
    reg_wr_in <= 1'b1;
    reg_addr_in <= a;
    reg_wdata_in <= v;
    @(posedge clk_in);
    reg_wr_in <= 1'b0;
  endtask

  task automatic rd(input logic [11:0] a, output logic [31:0] v);
    @(posedge clk_in);
    reg_rd_in <= 1'b1;
    reg_addr_in <= a;
    @(posedge clk_in);
    reg_rd_in <= 1'b0;
    #1 v = reg_rdata_out;
  endtask

  // one frame event pulse, then let flag and wake settle
  task automatic evt(input logic [5:0] v);
    @(posedge clk_in);
    rx_evt_in <= v;
    @(posedge clk_in);
    rx_evt_in <= '0;
    repeat (2) @(posedge clk_in);
    #1;
  endtask

  task automatic resume();
    @(posedge clk_in);
    resume_done_in <= 1'b1;
    @(posedge clk_in);
    resume_done_in <= 1'b0;
    repeat (2) @(posedge clk_in);
    #1;
  endtask

  task automatic mchk(input logic [5:0] idx, input logic [31:0] exp);
    @(posedge clk_in);
    match_idx_in <= idx;
    repeat (2) @(posedge clk_in);
    #1 chk("match data", exp, match_data_out);
  endtask

  // ----------------------------------------------------------------
  // scenarios
  // ----------------------------------------------------------------
  task automatic t_reset();
    rd(RWK_CONTROL_STATUS_OFS, d);
    chk("csr reset", 32'h0000_0000, d);
    rd(RWK_OPTIONS_OFS, d);
    chk("options reset", 32'h0000_0000, d);
    rd(12'h200, d);
    chk("unmapped", RWK_UNMAPPED_RD, d);
    mchk(6'h03, RWK_STORE_RST);
    $display("test reset done");
  endtask

  task automatic t_store();
    for (int i = 0; i < 40; i++) wr(RWK_PATTERN_PORT_OFS, 32'hA500_0000 | i);
    for (int i = 0; i < 40; i++)
    begin
      rd(RWK_PATTERN_PORT_OFS, d);
      chk("store read", 32'hA500_0000 | i, d);
    end
    wr(RWK_PATTERN_PORT_OFS, 32'h5A5A_0001);
    rd(RWK_PATTERN_PORT_OFS, d);
    chk("wrapped entry 0", 32'h5A5A_0001, d);
    wr(RWK_PATTERN_PORT_OFS, 32'h1111_0000);
    rd(RWK_PATTERN_PORT_OFS, d);
    chk("entry 1", 32'h1111_0000, d);
    wr(RWK_CONTROL_STATUS_OFS, 32'h8000_0000);
    rd(RWK_CONTROL_STATUS_OFS, d);
    chk("rewind self clears", 32'h0000_0000, d);
    rd(RWK_PATTERN_PORT_OFS, d);
    chk("read after rewind", 32'h5A5A_0001, d);
    wr(RWK_PATTERN_PORT_OFS, 32'h2222_0000);
    mchk(6'h00, 32'h2222_0000);
    mchk(6'h27, 32'hA500_0027);
    mchk(6'h28, 32'h0000_0000);
    $display("test store done");
  endtask

  task automatic t_events();
    evt(6'b011111);
    rd(RWK_CONTROL_STATUS_OFS, d);
    chk("invalid frame ignored", 32'h0000_0000, d);
    evt(6'b110001);
    chk("no wake when disabled", 32'h0, wake_req_out);
    rd(RWK_CONTROL_STATUS_OFS, d);
    chk("flag without enable", 32'h0000_0010, d);
    wr(RWK_CONTROL_STATUS_OFS, 32'h0000_0010);
    for (int i = 0; i < 4; i++)
    begin
      wr(RWK_CONTROL_STATUS_OFS, 32'h1 << i);
      evt(6'b110000 | (6'h01 << i));
      chk("wake raised", 32'h1, wake_req_out);
      rd(RWK_CONTROL_STATUS_OFS, d);
      chk("flag set", (32'h10 << i) | (32'h1 << i), d);
      wr(RWK_CONTROL_STATUS_OFS, (32'h10 << i) | (32'h1 << i));
      repeat (2) @(posedge clk_in);
      #1 chk("wake dropped", 32'h0, wake_req_out);
      rd(RWK_CONTROL_STATUS_OFS, d);
      chk("flag cleared", 32'h1 << i, d);
    end
    $display("test events done");
  endtask

  task automatic t_unicast();
    wr(RWK_CONTROL_STATUS_OFS, 32'h0000_0200);
    evt(6'b100000);
    chk("unicast needs pattern enable", 32'h0, wake_req_out);
    wr(RWK_CONTROL_STATUS_OFS, 32'h0000_0204);
    evt(6'b110000);
    chk("multicast no wake", 32'h0, wake_req_out);
    evt(6'b100000);
    chk("unicast wake", 32'h1, wake_req_out);
    resume();
    chk("unicast latch cleared", 32'h0, wake_req_out);
    $display("test unicast done");
  endtask

  task automatic t_resume();
    wr(RWK_CONTROL_STATUS_OFS, 32'h0000_0000);
    evt(6'b111111);
    resume();
    rd(RWK_CONTROL_STATUS_OFS, d);
    chk("resume without option", 32'h0000_00F0, d);
    wr(RWK_OPTIONS_OFS, 32'h0000_0001);
    rd(RWK_OPTIONS_OFS, d);
    chk("options", 32'h0000_0001, d);
    resume();
    rd(RWK_CONTROL_STATUS_OFS, d);
    chk("resume clears flags", 32'h0000_0000, d);
    $display("test resume done");
  endtask

  // ----------------------------------------------------------------
  // verdict and main sequence
  // ----------------------------------------------------------------
  task automatic end_sim();
    $display("checks %0d mismatches %0d", num_checks, error_cnt);
    if (error_cnt == 0 && num_checks > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask

  // main sequence
  initial
  begin
    repeat (6) @(posedge clk_in);
    arst_n_in <= 1'b1;
    t_reset();
    t_store();
    t_events();
    t_unicast();
    t_resume();
    end_sim();
  end

  // watchdog, far beyond the roughly 300 cycles the tests need
  initial
  begin
    #200000;
    error_cnt++;
    $display("Error watchdog expired");
    end_sim();
  end
endmodule
`default_nettype wire
